/* File: rtl/lsr_consts.vh */
// Constants for the link sync request block: control characters, select codes,
// multiframe defaults and reset values.
// Assumes it is included by bare name into every design file that needs it.
`ifndef LSR_CONSTS_VH
`define LSR_CONSTS_VH

// Source select codes
`define LSR_SEL_SINGLE 1'b0
`define LSR_SEL_DIFF 1'b1

// Control characters of the 8b/10b lane (octet before encoding, K flag set)
`define LSR_K_COMMA 8'hBC
`define LSR_K_MF_START 8'h1C
`define LSR_K_MF_ALIGN 8'h7C
`define LSR_K_CFG_START 8'h9C

// Position of the configuration start marker within the second multiframe
`define LSR_CFG_MARK_POS 1
// Index of the multiframe that carries the configuration
`define LSR_CFG_MF_INDEX 1

// Initial lane alignment sequence shape
`define LSR_OCTETS_PER_MF 32
`define LSR_ILAS_MF 4

// Reset values
`define LSR_RST_SYNC_N 1'b1
`define LSR_RST_OCTET 8'h00
`define LSR_RST_ENABLE 1'b0

`endif

/* File: rtl/lsr_sync_select.v */
// Sync request source selector: picks the single-ended pin or the differential pair.
// Assumes all pins are synchronous to CLK; the output is registered.
`timescale 1ns/1ns
`include "lsr_consts.vh"

module lsr_sync_select (
	input wire clk,
	input wire srst,
	input wire sel,
	input wire single_n,
	input wire diff_p,
	input wire diff_n,
	output reg sync_n
);

	reg diff_level;
	reg next_sync_n;

	// Differential decode: a valid pair shows its level on the plus leg, an equal pair holds
	always @* begin
		if (diff_p != diff_n) begin
			diff_level = diff_p;
		end else begin
			diff_level = sync_n;
		end
	end

	// Source mux; in differential mode the single-ended pin is ignored, it sits grounded
	always @* begin
		if (sel == `LSR_SEL_DIFF) begin
			next_sync_n = diff_level;
		end else begin
			next_sync_n = single_n;
		end
	end

	// Register the selected request
	always @(posedge clk) begin
		if (srst) begin
			sync_n <= `LSR_RST_SYNC_N;
		end else begin
			sync_n <= next_sync_n;
		end
	end

endmodule

/* File: rtl/lsr_link_sync_request.v */
// Link sync request handler and lane character sequencer for one serial lane.
// Assumes synchronous pins, one clock, and a receiver that drives the sync request.
// Assumes OCTETS_PER_MF from 3 to 256 and ILAS_MF up to 16, so the counters below are wide enough.
//
// What this block does
// - A low level on the selected sync request starts code group synchronization on the lane.
// - Once the request returns high after code group synchronization, the lane sends the alignment sequence.
// - With source select at 0 the request comes from the single-ended sync pin.
// - With source select at 1 the request comes from the differential timestamp pair.
// - A high power-down pin disables serializer and analog circuits; it is held low in normal use.
`timescale 1ns/1ns
`include "lsr_consts.vh"

module lsr_link_sync_request #(
	parameter OCTETS_PER_MF = `LSR_OCTETS_PER_MF,
	parameter ILAS_MF = `LSR_ILAS_MF
) (
	input wire CLK,
	input wire SRST,
	input wire SYNC_SOURCE_SELECT,
	input wire SINGLE_ENDED_LINK_SYNC_N,
	input wire TIMESTAMP_DIFF_INPUT_P,
	input wire TIMESTAMP_DIFF_INPUT_N,
	input wire ANALOG_POWERDOWN_PIN,
	input wire [7:0] SAMPLE_DATA,
	output reg [7:0] LANE_DATA,
	output reg LANE_IS_K,
	output reg [2:0] LINK_STATE,
	output reg SYNC_REQUEST_ACTIVE,
	output reg SERIALIZER_ENABLE,
	output reg ANALOG_ENABLE
);

	// Link states
	localparam [2:0] ST_OFF = 3'h0;
	localparam [2:0] ST_WAIT = 3'h1;
	localparam [2:0] ST_CGS = 3'h2;
	localparam [2:0] ST_ILAS = 3'h3;
	localparam [2:0] ST_DATA = 3'h4;

	// Counter widths and end values
	localparam OCT_W = 8;
	localparam MF_W = 4;
	// Full-width end values, cut to the counter widths on purpose
	localparam [31:0] OCT_LAST_FULL = OCTETS_PER_MF - 1;
	localparam [31:0] MF_LAST_FULL = ILAS_MF - 1;
	localparam [31:0] CFG_POS_FULL = `LSR_CFG_MARK_POS;
	localparam [31:0] CFG_MF_FULL = `LSR_CFG_MF_INDEX;
	localparam [OCT_W-1:0] OCT_LAST = OCT_LAST_FULL[OCT_W-1:0];
	localparam [MF_W-1:0] MF_LAST = MF_LAST_FULL[MF_W-1:0];
	localparam [OCT_W-1:0] CFG_POS = CFG_POS_FULL[OCT_W-1:0];
	localparam [MF_W-1:0] CFG_MF = CFG_MF_FULL[MF_W-1:0];

	wire sync_n;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [OCT_W-1:0] octet;
	reg [OCT_W-1:0] next_octet;
	reg [MF_W-1:0] mf;
	reg [MF_W-1:0] next_mf;
	reg [7:0] next_data;
	reg next_k;
	reg ilas_end;
	reg next_serializer_enable;
	reg next_analog_enable;

	// Request source selection and registering
	lsr_sync_select u_sel (
		.clk(CLK),
		.srst(SRST),
		.sel(SYNC_SOURCE_SELECT),
		.single_n(SINGLE_ENDED_LINK_SYNC_N),
		.diff_p(TIMESTAMP_DIFF_INPUT_P),
		.diff_n(TIMESTAMP_DIFF_INPUT_N),
		.sync_n(sync_n)
	);

	// Last octet of the last alignment multiframe
	always @* begin
		ilas_end = (octet == OCT_LAST) && (mf == MF_LAST);
	end

	// State transitions
	always @* begin
		next_state = state;
		if (ANALOG_POWERDOWN_PIN) begin
			next_state = ST_OFF;
		end else begin
			case (state)
				ST_OFF: begin
					next_state = ST_WAIT;
				end
				ST_WAIT: begin
					if (!sync_n) begin
						next_state = ST_CGS;
					end
				end
				ST_CGS: begin
					if (sync_n) begin
						next_state = ST_ILAS;
					end
				end
				ST_ILAS: begin
					if (!sync_n) begin
						next_state = ST_CGS;
					end else if (ilas_end) begin
						next_state = ST_DATA;
					end
				end
				ST_DATA: begin
					if (!sync_n) begin
						next_state = ST_CGS;
					end
				end
				default: begin
					next_state = ST_OFF;
				end
			endcase
		end
	end

	// Octet and multiframe counters, restarted on entry to the alignment sequence
	always @* begin
		next_octet = `LSR_RST_OCTET;
		next_mf = {MF_W{1'b0}};
		if (next_state == ST_ILAS && state == ST_ILAS) begin
			if (octet == OCT_LAST) begin
				next_octet = `LSR_RST_OCTET;
				next_mf = mf + 1'b1;
			end else begin
				next_octet = octet + 1'b1;
				next_mf = mf;
			end
		end
	end

	// Lane character for the coming cycle
	always @* begin
		next_data = 8'h00;
		next_k = 1'b0;
		case (next_state)
			ST_OFF: begin
				next_data = 8'h00;
				next_k = 1'b0;
			end
			ST_WAIT: begin
				next_data = `LSR_K_COMMA;
				next_k = 1'b1;
			end
			ST_CGS: begin
				next_data = `LSR_K_COMMA;
				next_k = 1'b1;
			end
			ST_ILAS: begin
				if (next_octet == {OCT_W{1'b0}}) begin
					next_data = `LSR_K_MF_START;
					next_k = 1'b1;
				end else if (next_octet == OCT_LAST) begin
					next_data = `LSR_K_MF_ALIGN;
					next_k = 1'b1;
				end else if (next_mf == CFG_MF && next_octet == CFG_POS) begin
					next_data = `LSR_K_CFG_START;
					next_k = 1'b1;
				end else begin
					next_data = next_octet; // Ramp fill inside each multiframe
					next_k = 1'b0;
				end
			end
			ST_DATA: begin
				next_data = SAMPLE_DATA;
				next_k = 1'b0;
			end
			default: begin
				next_data = 8'h00;
				next_k = 1'b0;
			end
		endcase
	end

	// Enables for the coming cycle; power-down wins over every link state
	always @* begin
		next_serializer_enable = (next_state != ST_OFF);
		next_analog_enable = !ANALOG_POWERDOWN_PIN;
	end

	// State and counters
	always @(posedge CLK) begin
		if (SRST) begin
			state <= ST_OFF;
			octet <= `LSR_RST_OCTET;
			mf <= {MF_W{1'b0}};
		end else begin
			state <= next_state;
			octet <= next_octet;
			mf <= next_mf;
		end
	end

	// Lane character and link status outputs
	always @(posedge CLK) begin
		if (SRST) begin
			LANE_DATA <= 8'h00;
			LANE_IS_K <= 1'b0;
			LINK_STATE <= ST_OFF;
			SYNC_REQUEST_ACTIVE <= 1'b0;
		end else begin
			LANE_DATA <= next_data;
			LANE_IS_K <= next_k;
			LINK_STATE <= next_state;
			SYNC_REQUEST_ACTIVE <= !sync_n;
		end
	end

	// Serializer and analog enables, low from reset until the first edge with power-down low
	always @(posedge CLK) begin
		if (SRST) begin
			SERIALIZER_ENABLE <= `LSR_RST_ENABLE;
			ANALOG_ENABLE <= `LSR_RST_ENABLE;
		end else begin
			SERIALIZER_ENABLE <= next_serializer_enable;
			ANALOG_ENABLE <= next_analog_enable;
		end
	end

endmodule

/* File: tb/lsr_rx_model.sv */
// Receiver model for the sync request pins; the bench sets req_n after each edge.
`timescale 1ns/1ns
module lsr_rx_model (
	input wire sel,
	input wire req_n,
	output wire single_n,
	output wire diff_p,
	output wire diff_n
);
	// Grounds the unused single-ended pin, idles the unused pair high
	assign single_n = sel ? 1'b0 : req_n;
	assign diff_p = sel ? req_n : 1'b1;
	assign diff_n = !diff_p;
endmodule

/* File: tb/lsr_link_sync_request_assertions.sv */
// Checker on the top ports; its counts match the bound instance.
`timescale 1ns/1ns
module lsr_chk #(parameter OCTETS_PER_MF = 32, parameter ILAS_MF = 4) (
	input wire CLK,
	input wire SRST,
	input wire SYNC_SOURCE_SELECT,
	input wire SINGLE_ENDED_LINK_SYNC_N,
	input wire TIMESTAMP_DIFF_INPUT_P,
	input wire TIMESTAMP_DIFF_INPUT_N,
	input wire ANALOG_POWERDOWN_PIN,
	input wire [2:0] LINK_STATE,
	input wire SYNC_REQUEST_ACTIVE,
	input wire SERIALIZER_ENABLE
);
	localparam N = OCTETS_PER_MF * ILAS_MF;
	// Low level on the selected request pins
	wire lo = SYNC_SOURCE_SELECT ? TIMESTAMP_DIFF_INPUT_N && !TIMESTAMP_DIFF_INPUT_P : !SINGLE_ENDED_LINK_SYNC_N;
	wire on = SERIALIZER_ENABLE;
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_powerdown_off: assert property (ANALOG_POWERDOWN_PIN |=> !on && LINK_STATE == 3'h0)
		else $error("link on in powerdown");
	a_req_low: assert property (lo |-> ##2 SYNC_REQUEST_ACTIVE) else $error("request missed");
	a_cgs_hold: assert property (SYNC_REQUEST_ACTIVE && on && $past(on) |-> LINK_STATE == 3'h2)
		else $error("no sync state");
	a_ilas_start: assert property ($fell(SYNC_REQUEST_ACTIVE) && on && $past(LINK_STATE) == 3'h2
		|-> LINK_STATE == 3'h3) else $error("no alignment");
	a_ilas_length: assert property (LINK_STATE == 3'h4 && $past(LINK_STATE) == 3'h3
		|-> $past(LINK_STATE, N + 1) == 3'h2) else $error("alignment length");
endmodule

/* File: tb/testbench.sv */
// Bench for the sync request block; assumes the receiver model and bound checker.
`timescale 1ns/1ns
module testbench;
	localparam OPM = 4;
	localparam IMF = 2;
	logic clk = 0, srst = 1, sel = 0, req_n = 1, powerdown = 0;
	logic [7:0] sd = 8'h00;
	logic [31:0] rnd = 32'd26;
	int n_fail = 0, tests_run = 0;
	wire s_n, d_p, d_n, k, sra, se, ae;
	wire [7:0] ld;
	wire [2:0] ls;
	wire [14:0] obs = {se, ae, sra, ls, k, ld};
	lsr_rx_model lsr_rx_model_i (.sel(sel), .req_n(req_n), .single_n(s_n), .diff_p(d_p), .diff_n(d_n));
	lsr_link_sync_request #(.OCTETS_PER_MF(OPM), .ILAS_MF(IMF)) lsr_link_sync_request_i (.CLK(clk),
		.SRST(srst), .SYNC_SOURCE_SELECT(sel), .SINGLE_ENDED_LINK_SYNC_N(s_n), .TIMESTAMP_DIFF_INPUT_P(d_p),
		.TIMESTAMP_DIFF_INPUT_N(d_n), .ANALOG_POWERDOWN_PIN(powerdown), .SAMPLE_DATA(sd), .LANE_DATA(ld),
		.LANE_IS_K(k), .LINK_STATE(ls), .SYNC_REQUEST_ACTIVE(sra), .SERIALIZER_ENABLE(se), .ANALOG_ENABLE(ae));
	// Clock
	initial forever #2 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// K flag and octet of alignment cycle i
	function automatic logic [8:0] ilas(input int i);
		int j;
		j = i % OPM;
		if (j == 0) return 9'h11C;
		if (j == OPM - 1) return 9'h17C;
		if (i / OPM == 1 && j == 1) return 9'h19C;
		return {1'b0, 8'(j)};
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [14:0] e);
		tests_run++;
		if (obs !== e) begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, obs, e);
		end
	endtask
	// Request low then high: sync, alignment, data
	task automatic bring_up(input logic s);
		int i;
		sel = s;
		rnd = xs(rnd);
		sd = rnd[7:0];
		req_n = 0;
		step(2);
		chk({6'h3A, 9'h1BC});
		req_n = 1;
		step(2);
		for (i = 0; i < OPM * IMF; i++) begin
			chk({6'h33, ilas(i)});
			step(1);
		end
		chk({7'h68, sd});
		$display("bring_up sel %0d done", s);
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		step(12);
		chk(15'h0000);
		srst = 0;
		step(1);
		chk({6'h31, 9'h1BC});
		bring_up(0);
		bring_up(1);
		bring_up(0);
		powerdown = 1;
		step(1);
		chk(15'h0000);
		powerdown = 0;
		step(1);
		chk({6'h31, 9'h1BC});
		$display("powerdown done");
		repeat (200) begin
			rnd = xs(rnd);
			{powerdown, sel, req_n} = {rnd[8:4] == 5'h00, rnd[0], rnd[3:1] != 3'h0};
			sd = rnd[15:8];
			step(rnd[19:16] + 1);
		end
		$display("random done");
		// Reset in mid-run, then a fresh bring-up from the waiting state the link enters after reset
		srst = 1;
		powerdown = 0;
		req_n = 1;
		step(2);
		chk(15'h0000);
		srst = 0;
		step(1);
		chk({6'h31, 9'h1BC});
		$display("reset done");
		rnd = xs(rnd);
		bring_up(rnd[0]);
		end_of_test();
	end
endmodule
bind lsr_link_sync_request lsr_chk #(.OCTETS_PER_MF(OCTETS_PER_MF), .ILAS_MF(ILAS_MF)) chk_i (.CLK(CLK),
	.SRST(SRST), .SYNC_SOURCE_SELECT(SYNC_SOURCE_SELECT), .SINGLE_ENDED_LINK_SYNC_N(SINGLE_ENDED_LINK_SYNC_N),
	.TIMESTAMP_DIFF_INPUT_P(TIMESTAMP_DIFF_INPUT_P), .TIMESTAMP_DIFF_INPUT_N(TIMESTAMP_DIFF_INPUT_N),
	.ANALOG_POWERDOWN_PIN(ANALOG_POWERDOWN_PIN), .LINK_STATE(LINK_STATE), .SYNC_REQUEST_ACTIVE(SYNC_REQUEST_ACTIVE),
	.SERIALIZER_ENABLE(SERIALIZER_ENABLE));
